// *** rtl/isp_consts.svh ***
// constants for the serial register pointer slave
`ifndef ISP_CONSTS_SVH
`define ISP_CONSTS_SVH

`define ISP_SLAVE_ADDR    7'h4C
`define ISP_WR_ADDR_BYTE  8'h98
`define ISP_RD_ADDR_BYTE  8'h99
`define ISP_PTR_RESET     7'h00
`define ISP_PTR_W         7
`define ISP_DATA_W        8
`define ISP_BIT_LAST      4'h8
`define ISP_IDLE_BYTE     8'hFF
`define ISP_BUF_DEPTH     2

`endif

// *** rtl/isp_pkg.sv ***
// types for the serial register pointer slave
package isp_pkg;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } isp_wr_word_type;

  typedef enum logic [2:0] {
    ISP_IDLE,
    ISP_RX,
    ISP_RX_ACK,
    ISP_TX,
    ISP_TX_ACK,
    ISP_IGNORE
  } isp_state_type;

  typedef enum logic [1:0] {
    ISP_BYTE_DEV,
    ISP_BYTE_REG,
    ISP_BYTE_DATA
  } isp_byte_type;

endpackage

// *** rtl/isp_buf.sv ***
// small valid/ready buffer for register write words
`timescale 1ns/10ps
module isp_buf #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_in,       // system clock
  input  wire logic             rst_n_in,     // synchronised reset, active low
  input  wire logic             in_valid_in,  // word offered
  output logic                  in_ready_out, // room for a word
  input  wire logic [WIDTH-1:0] in_data_in,   // word in
  output logic                  out_valid_out,// word available
  input  wire logic             out_ready_in, // consumer takes word
  output logic [WIDTH-1:0]      out_data_out  // word out
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready_out  = (count_reg != (AW+1)'(DEPTH));
  assign out_valid_out = (count_reg != '0);
  assign out_data_out  = mem_reg[rd_ptr_reg];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      if (push && !pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop && !push) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule // isp_buf

// *** rtl/isp_slave.sv ***
// two-wire slave with register pointer access to an internal register set
// Function
// (RQ1) master writes: address with write bit, bytes
// (RQ2) first byte after address is register address
// (RQ3) write address byte equals 0x98
// (RQ4) stop after register address writes nothing
// (RQ5) any stop clears pointer to 0x00
// (RQ6) repeated start keeps pointer unchanged
// (RQ7) first data byte stored at pointer
// (RQ8) pointer advances after each written byte
// (RQ9) reads fetch at pointer, then advance
// (RQ10) master sets pointer then repeated start reads
// (RQ11) read address byte equals 0x99
// (RQ12) return any number of consecutive bytes
// (RQ13) detect start plus own address, acknowledge
// (RQ14) slave address defaults to 0x4C
// (RQ15) acknowledge register and data bytes; a data byte is nacked while the previous word is still crossing
// (RQ16) master ends read with nack, stop
`timescale 1ns/10ps
`include "isp_consts.svh"
module isp_slave #(
  // (RQ14) own address
  parameter logic [6:0] SLAVE_ADDR = `ISP_SLAVE_ADDR,
  parameter int         BUF_DEPTH  = `ISP_BUF_DEPTH
) (
  input  wire logic                sys_clk_in,        // system clock, 100 MHz
  input  wire logic                reset_n_in,        // async reset, active low
  input  wire logic                link_clk_in,       // link sampling clock
  input  wire logic                scl_in,            // serial clock pin
  input  wire logic                sda_in,            // serial data pin level
  output logic                     sda_out,           // serial data drive value
  output logic                     sda_oe_n_out,      // low while driving sda
  output logic                     reg_wr_valid_out,  // write word available
  input  wire logic                reg_wr_ready_in,   // register set takes word
  output isp_pkg::isp_wr_word_type reg_wr_word_out,   // register address and data
  output logic                     reg_rd_en_out,     // read strobe, one cycle
  output logic [6:0]               reg_rd_addr_out,   // register address to read
  input  wire logic [7:0]          reg_rd_data_in     // data one cycle after strobe
);
  import isp_pkg::*;

  // reset release, both domains
  logic sys_rst_s1_reg;
  logic sys_rst_n;
  logic link_rst_s1_reg;
  logic link_rst_n;

  always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      sys_rst_s1_reg <= 1'b0;
      sys_rst_n      <= 1'b0;
    end else begin
      sys_rst_s1_reg <= 1'b1;
      sys_rst_n      <= sys_rst_s1_reg;
    end
  end

  always_ff @(posedge link_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      link_rst_s1_reg <= 1'b0;
      link_rst_n      <= 1'b0;
    end else begin
      link_rst_s1_reg <= 1'b1;
      link_rst_n      <= link_rst_s1_reg;
    end
  end

  // link domain: pin sampling and edges
  logic scl_s1_reg;
  logic scl_s2_reg;
  logic scl_d_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;
  logic sda_d_reg;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_d_reg  <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_d_reg  <= 1'b1;
    end else begin
      scl_s1_reg <= scl_in;
      scl_s2_reg <= scl_s1_reg;
      scl_d_reg  <= scl_s2_reg;
      sda_s1_reg <= sda_in;
      sda_s2_reg <= sda_s1_reg;
      sda_d_reg  <= sda_s2_reg;
    end
  end

  assign scl_rise  = scl_s2_reg && !scl_d_reg;
  assign scl_fall  = !scl_s2_reg && scl_d_reg;
  // (RQ13) start: sda falls while scl high
  assign start_det = scl_s2_reg && scl_d_reg && sda_d_reg && !sda_s2_reg;
  assign stop_det  = scl_s2_reg && scl_d_reg && !sda_d_reg && sda_s2_reg;

  // link domain: crossing handshakes
  logic            wr_req_tgl_reg;
  logic            wr_ack_s1_reg;
  logic            wr_ack_s2_reg;
  isp_wr_word_type wr_word_reg;
  logic            rd_req_tgl_reg;
  logic            rd_ack_s1_reg;
  logic            rd_ack_s2_reg;
  logic [6:0]      rd_addr_reg;
  logic            wr_busy;
  logic            rd_busy;
  logic            wr_ack_tgl_reg;
  logic            rd_ack_tgl_reg;
  logic [7:0]      rd_data_reg;

  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      wr_ack_s1_reg <= 1'b0;
      wr_ack_s2_reg <= 1'b0;
      rd_ack_s1_reg <= 1'b0;
      rd_ack_s2_reg <= 1'b0;
    end else begin
      wr_ack_s1_reg <= wr_ack_tgl_reg;
      wr_ack_s2_reg <= wr_ack_s1_reg;
      rd_ack_s1_reg <= rd_ack_tgl_reg;
      rd_ack_s2_reg <= rd_ack_s1_reg;
    end
  end

  assign wr_busy = wr_req_tgl_reg != wr_ack_s2_reg;
  assign rd_busy = rd_req_tgl_reg != rd_ack_s2_reg;

  // link domain: byte engine
  isp_state_type state_reg;
  isp_byte_type  byte_kind_reg;
  logic [3:0]    bit_cnt_reg;
  logic [7:0]    shift_reg;
  logic [6:0]    ptr_reg;
  logic          ack_ok_reg;
  logic          reading_reg;
  logic          drive_low_reg;
  logic          addr_match;
  logic          byte_done;

  // (RQ3) own address; bit 0 low means write
  assign addr_match = (shift_reg[7:1] == SLAVE_ADDR);
  assign byte_done  = scl_fall && (bit_cnt_reg == `ISP_BIT_LAST);

  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      state_reg      <= ISP_IDLE;
      byte_kind_reg  <= ISP_BYTE_DEV;
      bit_cnt_reg    <= 4'h0;
      shift_reg      <= 8'h00;
      ptr_reg        <= `ISP_PTR_RESET;
      ack_ok_reg     <= 1'b0;
      reading_reg    <= 1'b0;
      wr_req_tgl_reg <= 1'b0;
      wr_word_reg    <= '0;
      rd_req_tgl_reg <= 1'b0;
      rd_addr_reg    <= `ISP_PTR_RESET;
    end else if (stop_det) begin
      // (RQ5) stop clears pointer
      ptr_reg     <= `ISP_PTR_RESET;
      state_reg   <= ISP_IDLE;
      reading_reg <= 1'b0;
    end else if (start_det) begin
      // (RQ6) pointer kept on repeated start
      state_reg     <= ISP_RX;
      byte_kind_reg <= ISP_BYTE_DEV;
      bit_cnt_reg   <= 4'h0;
      reading_reg   <= 1'b0;
    end else begin
      case (state_reg)
        ISP_RX: begin
          if (scl_rise && bit_cnt_reg != `ISP_BIT_LAST) begin
            shift_reg   <= {shift_reg[6:0], sda_s2_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (byte_done) begin
            state_reg  <= ISP_RX_ACK;
            ack_ok_reg <= 1'b1;
            case (byte_kind_reg)
              ISP_BYTE_DEV: begin
                // (RQ13) acknowledge own address only
                ack_ok_reg <= addr_match;
                if (!addr_match) begin
                  state_reg <= ISP_IGNORE;
                end else if (shift_reg == {SLAVE_ADDR, 1'b1}) begin
                  // (RQ11) read address byte, prefetch at pointer
                  reading_reg    <= 1'b1;
                  rd_addr_reg    <= ptr_reg;
                  rd_req_tgl_reg <= ~rd_req_tgl_reg;
                end
              end
              ISP_BYTE_REG: begin
                // (RQ2) register address loads pointer
                ptr_reg <= shift_reg[6:0];
              end
              ISP_BYTE_DATA: begin
                if (wr_busy) begin
                  // previous word still crossing: refuse byte
                  ack_ok_reg <= 1'b0;
                end else begin
                  // (RQ7) store at pointer
                  wr_word_reg    <= '{addr: ptr_reg, data: shift_reg};
                  wr_req_tgl_reg <= ~wr_req_tgl_reg;
                  // (RQ8) advance after each byte
                  ptr_reg        <= ptr_reg + 7'h01;
                end
              end
              default: begin
                state_reg <= ISP_IGNORE;
              end
            endcase
          end
        end
        ISP_RX_ACK: begin
          if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (!ack_ok_reg) begin
              state_reg <= ISP_IGNORE;
            end else if (reading_reg) begin
              // (RQ12) first byte from pointer register
              shift_reg      <= rd_busy ? `ISP_IDLE_BYTE : rd_data_reg;
              // (RQ9) advance and prefetch next
              ptr_reg        <= ptr_reg + 7'h01;
              rd_addr_reg    <= ptr_reg + 7'h01;
              rd_req_tgl_reg <= ~rd_req_tgl_reg;
              state_reg      <= ISP_TX;
            end else begin
              // (RQ4) no word until a data byte completes
              state_reg     <= ISP_RX;
              byte_kind_reg <= (byte_kind_reg == ISP_BYTE_DEV) ? ISP_BYTE_REG
                                                               : ISP_BYTE_DATA;
            end
          end
        end
        ISP_TX: begin
          if (scl_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            shift_reg   <= {shift_reg[6:0], 1'b1};
            if (bit_cnt_reg == 4'h7) begin
              state_reg <= ISP_TX_ACK;
            end
          end
        end
        ISP_TX_ACK: begin
          if (scl_rise) begin
            ack_ok_reg <= !sda_s2_reg;
          end else if (scl_fall) begin
            bit_cnt_reg <= 4'h0;
            if (ack_ok_reg) begin
              // (RQ12) master acked: next consecutive byte
              shift_reg      <= rd_busy ? `ISP_IDLE_BYTE : rd_data_reg;
              ptr_reg        <= ptr_reg + 7'h01;
              rd_addr_reg    <= ptr_reg + 7'h01;
              rd_req_tgl_reg <= ~rd_req_tgl_reg;
              state_reg      <= ISP_TX;
            end else begin
              // (RQ16) nack ends read; wait for stop
              state_reg <= ISP_IGNORE;
            end
          end
        end
        ISP_IDLE, ISP_IGNORE: begin
          bit_cnt_reg <= 4'h0;
        end
        default: begin
          state_reg <= ISP_IDLE;
        end
      endcase
    end
  end

  // open-drain data: low for ack or a zero read bit
  always_ff @(posedge link_clk_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      drive_low_reg <= 1'b0;
    end else if (start_det || stop_det) begin
      drive_low_reg <= 1'b0;
    end else if (state_reg == ISP_RX && byte_done) begin
      // (RQ15) ack decided with the byte
      drive_low_reg <= (byte_kind_reg != ISP_BYTE_DEV || addr_match)
                       && !(byte_kind_reg == ISP_BYTE_DATA && wr_busy);
    end else if (state_reg == ISP_RX_ACK && scl_fall) begin
      drive_low_reg <= ack_ok_reg && reading_reg
                       && !(rd_busy ? 1'b1 : rd_data_reg[7]);
    end else if (state_reg == ISP_TX && scl_fall) begin
      drive_low_reg <= (bit_cnt_reg != 4'h7) && !shift_reg[6];
    end else if (state_reg == ISP_TX_ACK && scl_fall) begin
      drive_low_reg <= ack_ok_reg && !(rd_busy ? 1'b1 : rd_data_reg[7]);
    end
  end

  assign sda_out      = 1'b0;
  assign sda_oe_n_out = !drive_low_reg;

  // system domain: write words into the buffer
  logic wr_req_s1_reg;
  logic wr_req_s2_reg;
  logic rd_req_s1_reg;
  logic rd_req_s2_reg;
  logic wr_pend;
  logic rd_pend;
  logic buf_ready;
  logic rd_en_reg;
  logic [6:0] rd_addr_sys_reg;
  always_ff @(posedge sys_clk_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      wr_req_s1_reg <= 1'b0;
      wr_req_s2_reg <= 1'b0;
      rd_req_s1_reg <= 1'b0;
      rd_req_s2_reg <= 1'b0;
    end else begin
      wr_req_s1_reg <= wr_req_tgl_reg;
      wr_req_s2_reg <= wr_req_s1_reg;
      rd_req_s1_reg <= rd_req_tgl_reg;
      rd_req_s2_reg <= rd_req_s1_reg;
    end
  end

  assign wr_pend = wr_req_s2_reg != wr_ack_tgl_reg;
  assign rd_pend = rd_req_s2_reg != rd_ack_tgl_reg;

  // once a stalled register set fills the buffer, the ack is held back, so the link refuses data
  always_ff @(posedge sys_clk_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      wr_ack_tgl_reg <= 1'b0;
    end else if (wr_pend && buf_ready) begin
      wr_ack_tgl_reg <= ~wr_ack_tgl_reg;
    end
  end

  isp_buf #(
    .WIDTH ($bits(isp_wr_word_type)),
    .DEPTH (BUF_DEPTH)
  ) u_wr_buf (
    .clk_in        (sys_clk_in),
    .rst_n_in      (sys_rst_n),
    .in_valid_in   (wr_pend),
    .in_ready_out  (buf_ready),
    .in_data_in    (wr_word_reg),
    .out_valid_out (reg_wr_valid_out),
    .out_ready_in  (reg_wr_ready_in),
    .out_data_out  (reg_wr_word_out)
  );
  // system domain: register reads
  always_ff @(posedge sys_clk_in or negedge sys_rst_n) begin
    if (!sys_rst_n) begin
      rd_en_reg       <= 1'b0;
      rd_addr_sys_reg <= `ISP_PTR_RESET;
      rd_data_reg     <= `ISP_IDLE_BYTE;
      rd_ack_tgl_reg  <= 1'b0;
    end else if (rd_en_reg) begin
      rd_en_reg      <= 1'b0;
      rd_data_reg    <= reg_rd_data_in;
      rd_ack_tgl_reg <= ~rd_ack_tgl_reg;
    end else if (rd_pend) begin
      rd_en_reg       <= 1'b1;
      rd_addr_sys_reg <= rd_addr_reg;
    end
  end

  assign reg_rd_en_out   = rd_en_reg;
  assign reg_rd_addr_out = rd_addr_sys_reg;
endmodule // isp_slave

// *** verif/isp_slave_properties.sv ***
// port checks for the serial register pointer slave
`timescale 1ns/10ps
module isp_chk (
  input wire logic                     sys_clk_in,       // system clock
  input wire logic                     reset_n_in,       // async reset
  input wire logic                     link_clk_in,      // link clock
  input wire logic                     scl_in,           // serial clock
  input wire logic                     sda_in,           // data line
  input wire logic                     sda_out,          // data drive value
  input wire logic                     sda_oe_n_out,     // data drive enable
  input wire logic                     reg_wr_valid_out, // write word valid
  input wire logic                     reg_wr_ready_in,  // write word taken
  input wire isp_pkg::isp_wr_word_type reg_wr_word_out,  // write word
  input wire logic                     reg_rd_en_out,    // read strobe
  input wire logic [6:0]               reg_rd_addr_out,  // read address
  input wire logic [7:0]               reg_rd_data_in    // read data
);
  property p_rd_gap;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      reg_rd_en_out |=> !reg_rd_en_out [*8];
  endproperty
  a_rd_gap: assert property (p_rd_gap) else $error("read strobe too close");
  property p_rd_addr;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      reg_rd_en_out |=> $stable(reg_rd_addr_out);
  endproperty
  a_rd_addr: assert property (p_rd_addr) else $error("read address moved");
  property p_wr_valid;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      reg_wr_valid_out && !reg_wr_ready_in |=> reg_wr_valid_out;
  endproperty
  a_wr_valid: assert property (p_wr_valid) else $error("write word dropped");
  property p_wr_word;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      reg_wr_valid_out && !reg_wr_ready_in |=> $stable(reg_wr_word_out);
  endproperty
  a_wr_word: assert property (p_wr_word) else $error("write word changed");
  property p_rst_out;
    @(posedge sys_clk_in) disable iff (!reset_n_in)
      $rose(reset_n_in) |-> reg_rd_addr_out == 7'h00 && !reg_wr_valid_out && !reg_rd_en_out;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs not idle");
  property p_sda_val;
    @(posedge link_clk_in) disable iff (!reset_n_in)
      !sda_oe_n_out |-> !sda_out;
  endproperty
  a_sda_val: assert property (p_sda_val) else $error("data drive not low");
  property p_oe_low;
    @(posedge link_clk_in) disable iff (!reset_n_in)
      $changed(sda_oe_n_out) |-> !scl_in;
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("data moved in clock high");
  property p_rst_oe;
    @(posedge link_clk_in) disable iff (!reset_n_in)
      $rose(reset_n_in) |-> sda_oe_n_out [*3];
  endproperty
  a_rst_oe: assert property (p_rst_oe) else $error("data driven after reset");
endmodule // isp_chk

bind isp_slave isp_chk u_chk (
  .sys_clk_in, .reset_n_in, .link_clk_in, .scl_in, .sda_in, .sda_out, .sda_oe_n_out,
  .reg_wr_valid_out, .reg_wr_ready_in, .reg_wr_word_out, .reg_rd_en_out,
  .reg_rd_addr_out, .reg_rd_data_in
);

// *** verif/isp_master_model.sv ***
// two-wire bus master model paced by the bench clock
`timescale 1ns/10ps
module isp_master_model (
  input  wire logic clk_in,     // pacing clock, lines move on its fall
  input  wire logic sda_in,     // resolved data line
  output logic      scl_out,    // serial clock, idles high
  output logic      sda_low_out // high while pulling data low
);
  logic       ack_seen;
  logic [7:0] rx;

  initial begin
    scl_out = 1'b1;
    sda_low_out = 1'b0;
    ack_seen = 1'b0;
    rx = 8'h00;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk_in);
  endtask

  // data moves 5 cycles after the clock fall, so no false start or stop
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = !b;
    hold(20);
    scl_out = 1'b1;
    hold(20);
    r = sda_in;
    scl_out = 1'b0;
    hold(5);
  endtask

  task automatic start;
    sda_low_out = 1'b0;
    hold(20);
    scl_out = 1'b1;
    hold(20);
    sda_low_out = 1'b1;
    hold(20);
    scl_out = 1'b0;
    hold(5);
  endtask

  task automatic stop;
    sda_low_out = 1'b1;
    hold(20);
    scl_out = 1'b1;
    hold(20);
    sda_low_out = 1'b0;
    hold(20);
  endtask

  task automatic wr_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], r);
    end
    bit_io(1'b1, r);
    ack_seen = !r;
  endtask

  task automatic rd_byte(input logic last);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      rx[i] = r;
    end
    bit_io(last, r);
  endtask
endmodule // isp_master_model

// *** verif/isp_slave_bench.sv ***
// self-checking bench for the serial register pointer slave
`timescale 1ns/10ps
module isp_slave_bench;
  import isp_pkg::*;
  logic            sys_clk;
  logic            link_clk;
  logic            reset_n;
  logic            scl;
  logic            sda_low;
  logic            sda_o;
  logic            sda_oe_n;
  logic            wr_valid;
  logic            wr_ready;
  isp_wr_word_type wr_word;
  logic            rd_en;
  logic [6:0]      rd_addr;
  logic [7:0]      rd_data;
  wire             sda_w;
  isp_wr_word_type wq[$];
  int              fails;
  int              checked;

  // pulled up, low while either side pulls
  assign sda_w = !sda_low && (sda_oe_n || sda_o);

  isp_slave dut (
    .sys_clk_in      (sys_clk),
    .reset_n_in      (reset_n),
    .link_clk_in     (link_clk),
    .scl_in          (scl),
    .sda_in          (sda_w),
    .sda_out         (sda_o),
    .sda_oe_n_out    (sda_oe_n),
    .reg_wr_valid_out(wr_valid),
    .reg_wr_ready_in (wr_ready),
    .reg_wr_word_out (wr_word),
    .reg_rd_en_out   (rd_en),
    .reg_rd_addr_out (rd_addr),
    .reg_rd_data_in  (rd_data)
  );

  isp_master_model m (
    .clk_in     (sys_clk),
    .sda_in     (sda_w),
    .scl_out    (scl),
    .sda_low_out(sda_low)
  );

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  initial begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end

  function automatic logic [7:0] rdv(input logic [6:0] a);
    return {1'b0, a} ^ 8'hA5;
  endfunction

  // register set answers the edge after the strobe
  always @(negedge sys_clk) begin
    if (rd_en === 1'b1) begin
      rd_data <= rdv(rd_addr);
    end
  end

  always @(posedge sys_clk) begin
    if (wr_valid === 1'b1 && wr_ready === 1'b1) begin
      wq.push_back(wr_word);
    end
  end

  task automatic check(input logic [14:0] seen, input logic [14:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results;
    if (fails == 0 && checked > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic wait_words(input int n);
    for (int i = 0; i < 400 && wq.size() < n; i++) begin
      @(negedge sys_clk);
    end
    if (wq.size() < n) begin
      fails++;
      results();
    end
  endtask

  task automatic wb(input logic [7:0] b, input logic exp);
    m.wr_byte(b);
    check(15'(m.ack_seen), 15'(exp));
  endtask

  task automatic t_write;
    m.start();
    wb(8'h98, 1'b1);
    wb(8'h7E, 1'b1);
    for (int i = 0; i < 3; i++) begin
      wb(8'hA1 + 8'(i), 1'b1);
    end
    m.stop();
    wait_words(3);
    for (int i = 0; i < 3; i++) begin
      check(wq.pop_front(), {7'h7E + 7'(i), 8'hA1 + 8'(i)});
    end
  endtask

  task automatic t_nodata;
    m.start();
    wb(8'h98, 1'b1);
    wb(8'h10, 1'b1);
    m.stop();
    m.hold(100);
    check(15'(wq.size()), 15'h0);
    m.start();
    wb(8'h99, 1'b1);
    m.rd_byte(1'b1);
    m.stop();
    check(15'(m.rx), 15'(rdv(7'h00)));
  endtask

  task automatic t_read;
    m.start();
    wb(8'h98, 1'b1);
    wb(8'h7F, 1'b1);
    m.start();
    wb(8'h99, 1'b1);
    for (int i = 0; i < 3; i++) begin
      m.rd_byte(i == 2);
      check(15'(m.rx), 15'(rdv(7'h7F + 7'(i))));
    end
    m.stop();
  endtask

  task automatic t_bad;
    m.start();
    wb(8'h9A, 1'b0);
    wb(8'h55, 1'b0);
    m.stop();
  endtask

  // far side stalls; every acknowledged byte must still arrive
  task automatic t_stall;
    int n;
    n = 0;
    wr_ready = 1'b0;
    m.start();
    wb(8'h98, 1'b1);
    wb(8'h20, 1'b1);
    for (int i = 0; i < 4; i++) begin
      m.wr_byte(8'hC0 + 8'(i));
      n += int'(m.ack_seen);
    end
    m.stop();
    check(15'(n), 15'h3);
    check(15'(wq.size()), 15'h0);
    wr_ready = 1'b1;
    wait_words(n);
    m.hold(50);
    check(15'(wq.size()), 15'(n));
    for (int i = 0; i < n; i++) begin
      check(wq.pop_front(), {7'h20 + 7'(i), 8'hC0 + 8'(i)});
    end
  endtask

  initial begin
    fails = 0;
    checked = 0;
    reset_n = 1'b0;
    wr_ready = 1'b1;
    rd_data = 8'h00;
    repeat (5) @(negedge link_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    m.hold(20);
    t_write();
    t_nodata();
    t_read();
    t_bad();
    t_stall();
    results();
  end
endmodule // isp_slave_bench
